// ---- core/sge_group.sv ----
`timescale 1ns/10ps
module sge_group #(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // Control side
    sge_grp_if.grp    g
);

    localparam logic [W-1:0] IMPL = (W == sge_pkg::WIDE) ?
        sge_pkg::IMPL_WIDE[W-1:0] : sge_pkg::IMPL_NARROW[W-1:0]; // R14

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] prev;
        logic [W-1:0] ptr;
        logic [W-1:0] ntr;
        logic [W-1:0] en;
        logic [W-1:0] evt;
    } sge_grp_s;

    localparam sge_grp_s RST = '{
        s1: '0, s2: '0, prev: '0,
        ptr: sge_pkg::PTR_RST[W-1:0] & IMPL,
        ntr: sge_pkg::NTR_RST[W-1:0],
        en: sge_pkg::EN_RST[W-1:0],
        evt: '0};

    sge_grp_s     st_ff;
    sge_grp_s     nxt_st;
    logic [W-1:0] cond;
    logic [W-1:0] rise;
    logic [W-1:0] fall;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.s1 = g.cond_pin;
        nxt_st.s2 = st_ff.s1;
        // Live view, no latching
        cond = ((st_ff.s2 & ~g.int_sel) | (g.cond_int & g.int_sel))
               & IMPL; // R01
        nxt_st.prev = cond; // R15
        rise = cond & ~st_ff.prev & st_ff.ptr; // R02
        fall = ~cond & st_ff.prev & st_ff.ntr; // R02
        // New events win over a read clear
        nxt_st.evt = ((st_ff.evt & ~g.clr_mask) | rise | fall)
                     & IMPL; // R05 R06 R15
        if (g.preset)
        begin
            nxt_st.ptr = IMPL; // R04
            nxt_st.ntr = '0; // R04
        end
        else
        begin
            if (g.wr_ptr)
                nxt_st.ptr = g.wdata & IMPL; // R03
            if (g.wr_ntr)
                nxt_st.ntr = g.wdata & IMPL; // R03
        end
        if (g.wr_en)
            nxt_st.en = g.wdata & IMPL; // R09
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            st_ff <= RST;
        else
            st_ff <= nxt_st;
    end

    // All four parts always present and visible
    assign g.cond    = cond; // R10
    assign g.ptr     = st_ff.ptr;
    assign g.ntr     = st_ff.ntr;
    assign g.evt     = st_ff.evt;
    assign g.en      = st_ff.en;
    assign g.summary = |(st_ff.evt & st_ff.en); // R08 R16

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_evt_on_rise: assert property ( // R05
        (rise != '0) |=> ((st_ff.evt & $past(rise)) == $past(rise)))
        else $error("selected rising edge did not set event");
    a_evt_on_fall: assert property ( // R02
        (fall != '0) |=> ((st_ff.evt & $past(fall)) == $past(fall)))
        else $error("selected falling edge did not set event");
    a_evt_holds: assert property ( // R06
        ##1 (($past(st_ff.evt) & ~$past(g.clr_mask) & ~st_ff.evt) == '0))
        else $error("event bit dropped without a clear");
    a_evt_no_spur: assert property ( // R02
        ##1 ((st_ff.evt & ~$past(st_ff.evt)
              & ~($past(rise) | $past(fall))) == '0))
        else $error("event bit set without a selected edge");
    a_preset_vals: assert property ( // R04
        g.preset |=> (st_ff.ptr == IMPL) && (st_ff.ntr == '0))
        else $error("preset left wrong filter values");
    a_filt_stable: assert property ( // R03
        (!g.preset && !g.wr_ptr && !g.wr_ntr) |=>
            $stable(st_ff.ptr) && $stable(st_ff.ntr))
        else $error("filter changed without a write");
    a_en_stable: assert property ( // R09
        !g.wr_en |=> $stable(st_ff.en))
        else $error("enable changed without a write");
    a_msb_zero: assert property ( // R14
        ((st_ff.evt | st_ff.ptr | st_ff.ntr | st_ff.en | cond)
         & ~IMPL) == '0)
        else $error("unused bit reads as one");

    c_evt_set: cover property ((rise | fall) != '0);

endmodule : sge_group

// ---- core/sge_grp_if.sv ----
`timescale 1ns/10ps
interface sge_grp_if #(parameter int W = 16);
    logic [W-1:0] cond_pin;
    logic [W-1:0] cond_int;
    logic [W-1:0] int_sel;
    logic [W-1:0] wdata;
    logic [W-1:0] clr_mask;
    logic         wr_ptr;
    logic         wr_ntr;
    logic         wr_en;
    logic         preset;
    logic [W-1:0] cond;
    logic [W-1:0] ptr;
    logic [W-1:0] ntr;
    logic [W-1:0] evt;
    logic [W-1:0] en;
    logic         summary;

    modport grp (
        input  cond_pin, cond_int, int_sel, wdata, clr_mask,
        input  wr_ptr, wr_ntr, wr_en, preset,
        output cond, ptr, ntr, evt, en, summary
    );
    modport ctl (
        output cond_pin, cond_int, int_sel, wdata, clr_mask,
        output wr_ptr, wr_ntr, wr_en, preset,
        input  cond, ptr, ntr, evt, en, summary
    );
endinterface : sge_grp_if

// ---- core/sge_pkg.sv ----
package sge_pkg;

    // Group indices and widths
    localparam int NGRP     = 5;
    localparam int GRP_STB  = 0;
    localparam int GRP_ESE  = 1;
    localparam int GRP_OPER = 2;
    localparam int GRP_QUES = 3;
    localparam int GRP_DEV  = 4;
    localparam int NARROW   = 8;
    localparam int WIDE     = 16;

    // Implemented bits; top bit of a wide group always zero
    localparam logic [15:0] IMPL_WIDE   = 16'h7FFF;
    localparam logic [15:0] IMPL_NARROW = 16'h00FF;

    // Reset and preset values
    localparam logic [15:0] PTR_RST = 16'hFFFF;
    localparam logic [15:0] NTR_RST = 16'h0000;
    localparam logic [15:0] EN_RST  = 16'h0000;
    localparam logic [4:0]  IRQ_RST = 5'h00;

    // Address map: paddr[7:5] selects group, paddr[4:2] register
    localparam int         ADDR_W   = 8;
    localparam logic [2:0] REG_COND = 3'h0;
    localparam logic [2:0] REG_PTR  = 3'h1;
    localparam logic [2:0] REG_NTR  = 3'h2;
    localparam logic [2:0] REG_EVT  = 3'h3;
    localparam logic [2:0] REG_EN   = 3'h4;
    localparam logic [2:0] GRP_LAST = 3'h4;
    localparam logic [2:0] MISC_GRP = 3'h5;
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_ISTA = 3'h1;
    localparam logic [2:0] REG_IMSK = 3'h2;

    // Control register bits
    localparam int CTRL_CLS_BIT    = 0;
    localparam int CTRL_PRESET_BIT = 1;

    // Status byte condition bits fed by group summaries
    localparam int          STB_DEV_BIT  = 1;
    localparam int          STB_QUES_BIT = 3;
    localparam int          STB_ESE_BIT  = 5;
    localparam int          STB_OPER_BIT = 7;
    localparam logic [15:0] STB_INT_SEL  = 16'h00AA;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic [4:0]  sum_prev;
        logic [4:0]  sum_out;
        logic [4:0]  irq_stat;
        logic [4:0]  irq_mask;
        logic        irq;
    } sge_top_s;

endpackage : sge_pkg

// ---- core/sge_top.sv ----
// Operation
// R01 - A condition register tracks its live inputs and cannot be written.
// R02 - Per bit, rising and falling filter bits pick which edges set events.
// R03 - Filter registers are read/write; clear-status and reads keep them.
// R04 - A preset makes the falling filter all zero and rising filter all ones.
// R05 - Every edge chosen by the filters sets the matching event bit.
// R06 - A set event bit stays set until its register is read or cleared.
// R07 - Event registers ignore writes; only reads and clear-status clear them.
// R08 - A group summary is the OR of event bits ANDed with enable bits.
// R09 - Enable registers are read/write and reading leaves them intact.
// R10 - Each group holds condition, filters, event and enable in full.
// R11 - Groups are status byte, standard, operation, questionable and device.
// R12 - The remote side uses common commands or the status subsystem to reach.
// R13 - Operation and questionable groups are 16 wide; status byte and std 8.
// R14 - The top bit of each 16-bit group is unused and reads zero.
// R15 - Edges compare with last clock's value; a new event beats a read clear.
// R16 - Summaries follow event and enable within one clock.
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module sge_top (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             reset_n,
    // APB slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output      logic [31:0]      prdata,
    output      logic             pready,
    output      logic             pslverr,
    // Monitored conditions, one lane per group
    input  wire logic [4:0][15:0] cond_pin,
    // Summaries and interrupt
    output      logic [4:0]       summary,
    output      logic             irq
);

    logic [1:0]        rst_sync_ff;
    logic              rst_n;
    sge_pkg::sge_top_s st_ff;
    sge_pkg::sge_top_s nxt_st;

    logic [4:0][15:0]  cond_a;
    logic [4:0][15:0]  ptr_a;
    logic [4:0][15:0]  ntr_a;
    logic [4:0][15:0]  evt_a;
    logic [4:0][15:0]  en_a;
    logic [4:0]        sum_a;
    logic [15:0]       stb_int;

    logic [4:0]        wr_ptr_v;
    logic [4:0]        wr_ntr_v;
    logic [4:0]        wr_en_v;
    logic [4:0][15:0]  clr_v;
    logic              preset_c;

    logic              setup;
    logic              acc;
    logic [2:0]        grp;
    logic [2:0]        ridx;
    logic              in_grp;
    logic              in_misc;
    logic [31:0]       rd_val;
    logic [4:0]        irq_clr;
    logic [4:0]        sum_rise;

    // Reset release through two flops
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            rst_sync_ff <= 2'h0;
        else
            rst_sync_ff <= {rst_sync_ff[0], 1'h1};
    end

    assign rst_n = rst_sync_ff[1];

    // Summaries of the other groups feed status byte conditions
    always_comb
    begin
        stb_int = 16'h0000;
        stb_int[sge_pkg::STB_DEV_BIT]  = sum_a[sge_pkg::GRP_DEV];
        stb_int[sge_pkg::STB_QUES_BIT] = sum_a[sge_pkg::GRP_QUES];
        stb_int[sge_pkg::STB_ESE_BIT]  = sum_a[sge_pkg::GRP_ESE];
        stb_int[sge_pkg::STB_OPER_BIT] = sum_a[sge_pkg::GRP_OPER];
    end

    // Five status groups, two narrow then three wide
    for (genvar i = 0; i < sge_pkg::NGRP; i++)
    begin : g_grp
        localparam int W = (i < 2) ? sge_pkg::NARROW : sge_pkg::WIDE; // R13
        localparam logic [15:0] SEL =
            (i == sge_pkg::GRP_STB) ? sge_pkg::STB_INT_SEL : 16'h0000;

        sge_grp_if #(.W(W)) gi ();

        sge_group #(.W(W)) u_grp ( // R11
            .mclk  (mclk),
            .rst_n (rst_n),
            .g     (gi.grp)
        );

        assign gi.cond_pin = cond_pin[i][W-1:0];
        assign gi.cond_int = stb_int[W-1:0];
        assign gi.int_sel  = SEL[W-1:0];
        assign gi.wdata    = pwdata[W-1:0];
        assign gi.clr_mask = clr_v[i][W-1:0];
        assign gi.wr_ptr   = wr_ptr_v[i];
        assign gi.wr_ntr   = wr_ntr_v[i];
        assign gi.wr_en    = wr_en_v[i];
        assign gi.preset   = preset_c;
        assign cond_a[i]   = 16'(gi.cond);
        assign ptr_a[i]    = 16'(gi.ptr);
        assign ntr_a[i]    = 16'(gi.ntr);
        assign evt_a[i]    = 16'(gi.evt);
        assign en_a[i]     = 16'(gi.en);
        assign sum_a[i]    = gi.summary;
    end

    always_comb
    begin
        nxt_st   = st_ff;
        setup    = psel & ~penable;
        acc      = psel & penable & st_ff.pready;
        grp      = paddr[7:5];
        ridx     = paddr[4:2];
        in_grp   = (grp <= sge_pkg::GRP_LAST) && (ridx <= sge_pkg::REG_EN);
        in_misc  = (grp == sge_pkg::MISC_GRP)
                   && (ridx <= sge_pkg::REG_IMSK);
        rd_val   = 32'h0000_0000;
        wr_ptr_v = 5'h00;
        wr_ntr_v = 5'h00;
        wr_en_v  = 5'h00;
        clr_v    = '0;
        preset_c = 1'h0;
        irq_clr  = 5'h00;

        // Read mux; no read has a side effect on filters or enables
        if (in_grp)
        begin
            case (ridx)
                sge_pkg::REG_COND: rd_val = {16'h0000, cond_a[grp]}; // R01
                sge_pkg::REG_PTR:  rd_val = {16'h0000, ptr_a[grp]}; // R03
                sge_pkg::REG_NTR:  rd_val = {16'h0000, ntr_a[grp]}; // R03
                sge_pkg::REG_EVT:  rd_val = {16'h0000, evt_a[grp]};
                sge_pkg::REG_EN:   rd_val = {16'h0000, en_a[grp]}; // R09
                default:           rd_val = 32'h0000_0000;
            endcase
        end
        else if (in_misc)
        begin
            case (ridx)
                sge_pkg::REG_ISTA: rd_val = {27'h0, st_ff.irq_stat};
                sge_pkg::REG_IMSK: rd_val = {27'h0, st_ff.irq_mask};
                default:           rd_val = 32'h0000_0000;
            endcase
        end

        // Answer in the first access cycle
        nxt_st.pready  = setup;
        nxt_st.pslverr = setup & ~(in_grp | in_misc);
        nxt_st.prdata  = (setup & ~pwrite) ? rd_val : 32'h0000_0000;

        if (acc && pwrite && in_grp)
        begin
            // Writes to condition and event registers fall through
            case (ridx)
                sge_pkg::REG_PTR: wr_ptr_v[grp] = 1'h1; // R03
                sge_pkg::REG_NTR: wr_ntr_v[grp] = 1'h1; // R03
                sge_pkg::REG_EN:  wr_en_v[grp]  = 1'h1; // R09
                default:          wr_en_v       = 5'h00; // R07
            endcase
        end

        // Clear only the bits that were returned
        if (acc && !pwrite && in_grp && ridx == sge_pkg::REG_EVT)
            clr_v[grp] = st_ff.prdata[15:0]; // R06 R15

        if (acc && pwrite && in_misc && ridx == sge_pkg::REG_CTRL)
        begin
            if (pwdata[sge_pkg::CTRL_CLS_BIT])
                clr_v = '1; // R06
            preset_c = pwdata[sge_pkg::CTRL_PRESET_BIT]; // R04
        end

        if (acc && pwrite && in_misc && ridx == sge_pkg::REG_IMSK)
            nxt_st.irq_mask = pwdata[4:0];
        if (acc && !pwrite && in_misc && ridx == sge_pkg::REG_ISTA)
            irq_clr = st_ff.prdata[4:0];

        // Summary edges set sticky interrupt bits; set beats clear
        sum_rise        = sum_a & ~st_ff.sum_prev;
        nxt_st.sum_prev = sum_a;
        nxt_st.sum_out  = sum_a; // R16
        nxt_st.irq_stat = (st_ff.irq_stat & ~irq_clr) | sum_rise;
        nxt_st.irq      = |(nxt_st.irq_stat & nxt_st.irq_mask);
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_ff          <= '0;
            st_ff.irq_stat <= sge_pkg::IRQ_RST;
            st_ff.irq_mask <= sge_pkg::IRQ_RST;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign prdata  = st_ff.prdata;
    assign pready  = st_ff.pready;
    assign pslverr = st_ff.pslverr;
    assign summary = st_ff.sum_out;
    assign irq     = st_ff.irq;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_sum_fresh: assert property ( // R16
        ##1 (summary == $past(sum_a)))
        else $error("summary output lags more than one clock");
    a_irq_level: assert property (
        irq == |(st_ff.irq_stat & st_ff.irq_mask))
        else $error("interrupt does not match masked status");
    a_apb_answer: assert property (
        (psel && !penable) |=> pready)
        else $error("no answer in first access cycle");
    a_evt_write_ro: assert property ( // R07
        (acc && pwrite && in_grp && ridx == sge_pkg::REG_EVT) |->
            (wr_ptr_v == 5'h00) && (wr_en_v == 5'h00) && (clr_v == '0))
        else $error("event register write had an effect");

    // Bus answer
    a_ready_once: assert property (
        (psel && penable) |=> !pready)
        else $error("ready held for more than one cycle");
    a_err_unmapped: assert property (
        (setup && !(in_grp || in_misc)) |=> (pready && pslverr))
        else $error("unmapped access did not report an error");
    a_err_mapped: assert property (
        (setup && (in_grp || in_misc)) |=> (pready && !pslverr))
        else $error("mapped access reported an error");
    a_rdata_idle: assert property (
        !pready |-> (prdata == 32'h0000_0000))
        else $error("read data outside the ready cycle");
    a_wdata_quiet: assert property (
        (setup && pwrite) |=> (prdata == 32'h0000_0000))
        else $error("write returned read data");

    // Register side effects
    a_cond_write_ro: assert property ( // R01
        (acc && pwrite && in_grp && ridx == sge_pkg::REG_COND) |->
            ((wr_ptr_v | wr_ntr_v | wr_en_v) == 5'h00) && (clr_v == '0))
        else $error("condition register write had an effect");
    a_read_keeps: assert property ( // R03 R09
        (acc && !pwrite) |->
            ((wr_ptr_v | wr_ntr_v | wr_en_v) == 5'h00) && !preset_c)
        else $error("read changed a filter or enable");
    a_clr_source: assert property ( // R07
        (!(acc && !pwrite && in_grp && ridx == sge_pkg::REG_EVT)
         && !(acc && pwrite && in_misc && ridx == sge_pkg::REG_CTRL))
        |-> (clr_v == '0))
        else $error("event cleared by something else");
    a_wr_single: assert property (
        $onehot0({wr_ptr_v, wr_ntr_v, wr_en_v}))
        else $error("one transfer wrote more than one register");
    a_preset_src: assert property ( // R04
        preset_c |-> (acc && pwrite && in_misc))
        else $error("preset without a control write");

    // Interrupt status
    a_ista_sticky: assert property (
        ##1 (($past(st_ff.irq_stat) & ~$past(irq_clr)
              & ~st_ff.irq_stat) == 5'h00))
        else $error("interrupt status bit dropped without a read");
    a_ista_set: assert property (
        (sum_rise != 5'h00) |=>
            ((st_ff.irq_stat & $past(sum_rise)) == $past(sum_rise)))
        else $error("summary rise did not set interrupt status");
    a_mask_hold: assert property (
        !(acc && pwrite && in_misc && ridx == sge_pkg::REG_IMSK) |=>
            $stable(st_ff.irq_mask))
        else $error("interrupt mask changed without a write");

    // Group shape
    a_narrow_hi: assert property ( // R13
        ((cond_a[0] | ptr_a[0] | ntr_a[0] | evt_a[0] | en_a[0]
          | cond_a[1] | ptr_a[1] | ntr_a[1] | evt_a[1] | en_a[1])
         & ~sge_pkg::IMPL_NARROW) == 16'h0000)
        else $error("narrow group shows bits above its width");
    a_stb_feed: assert property ( // R11
        (cond_a[sge_pkg::GRP_STB] & sge_pkg::STB_INT_SEL) == stb_int)
        else $error("status byte does not follow group summaries");

    c_evt_read: cover property (
        acc && !pwrite && in_grp && ridx == sge_pkg::REG_EVT
        && st_ff.prdata != 32'h0000_0000);
    c_irq_fire: cover property ($rose(irq));
    c_preset: cover property (preset_c);
    c_cls: cover property (
        acc && pwrite && in_misc && ridx == sge_pkg::REG_CTRL
        && pwdata[sge_pkg::CTRL_CLS_BIT]);

endmodule : sge_top

// ---- tb/sge_top_tb.sv ----
`timescale 1ns/10ps
module sge_top_tb;
    logic             mclk;
    logic             reset_n;
    logic             psel;
    logic             penable;
    logic             pwrite;
    logic [7:0]       paddr;
    logic [31:0]      pwdata;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic [4:0][15:0] cond_pin;
    logic [4:0]       summary;
    logic             irq;
    logic [31:0]      rd;
    logic             err;
    int               n_fail;
    int               comparisons;

    sge_top dut_u (
        .mclk     (mclk),
        .reset_n  (reset_n),
        .psel     (psel),
        .penable  (penable),
        .pwrite   (pwrite),
        .paddr    (paddr),
        .pwdata   (pwdata),
        .prdata   (prdata),
        .pready   (pready),
        .pslverr  (pslverr),
        .cond_pin (cond_pin),
        .summary  (summary),
        .irq      (irq)
    );

    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    function automatic logic [7:0] ad(input logic [2:0] g,
                                      input logic [2:0] r);
        ad = {g, r, 2'h0};
    endfunction : ad

    task automatic chk(input string w, input logic [31:0] e,
                       input logic [31:0] s);
        comparisons++;
        if (s !== e)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", w, e, s);
        end
    endtask : chk

    // Setup cycle, then hold until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do
            @(posedge mclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rc(input string w, input logic [7:0] a,
                      input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(w, e, rd);
    endtask : rc

    task automatic pin(input int g, input int b, input logic v);
        @(posedge mclk);
        cond_pin[g][b] <= v;
        repeat (6) @(posedge mclk);
    endtask : pin

    task automatic t_reset;
        for (int g = 0; g < 5; g++)
        begin
            rc("ptr", ad(g, sge_pkg::REG_PTR),
               g < 2 ? 32'hFF : 32'h7FFF);
            rc("ntr", ad(g, sge_pkg::REG_NTR), 32'h0);
            rc("en", ad(g, sge_pkg::REG_EN), 32'h0);
            rc("evt", ad(g, sge_pkg::REG_EVT), 32'h0);
        end
    endtask : t_reset

    task automatic t_filters;
        wr(ad(2, sge_pkg::REG_PTR), 32'hFFFF);
        rc("ptr wide", ad(2, sge_pkg::REG_PTR), 32'h7FFF);
        wr(ad(1, sge_pkg::REG_PTR), 32'hFFFF);
        rc("ptr narrow", ad(1, sge_pkg::REG_PTR), 32'hFF);
        wr(ad(2, sge_pkg::REG_NTR), 32'h1234);
        rc("ntr", ad(2, sge_pkg::REG_NTR), 32'h1234);
        wr(ad(sge_pkg::MISC_GRP, sge_pkg::REG_CTRL), 32'h1);
        rc("ntr kept", ad(2, sge_pkg::REG_NTR), 32'h1234);
        wr(ad(2, sge_pkg::REG_NTR), 32'h0);
    endtask : t_filters

    task automatic t_rise;
        pin(2, 0, 1'b1);
        rc("cond", ad(2, sge_pkg::REG_COND), 32'h1);
        wr(ad(2, sge_pkg::REG_COND), 32'h0);
        rc("cond ro", ad(2, sge_pkg::REG_COND), 32'h1);
        rc("evt rise", ad(2, sge_pkg::REG_EVT), 32'h1);
        pin(2, 0, 1'b0);
        rc("evt cleared", ad(2, sge_pkg::REG_EVT), 32'h0);
        pin(2, 0, 1'b1);
        pin(2, 0, 1'b0);
        wr(ad(2, sge_pkg::REG_EVT), 32'h0);
        rc("evt held", ad(2, sge_pkg::REG_EVT), 32'h1);
        wr(ad(2, sge_pkg::REG_EVT), 32'hFFFF);
        rc("evt ro", ad(2, sge_pkg::REG_EVT), 32'h0);
        pin(2, 15, 1'b1);
        rc("cond top", ad(2, sge_pkg::REG_COND), 32'h0);
        rc("evt top", ad(2, sge_pkg::REG_EVT), 32'h0);
        pin(2, 15, 1'b0);
    endtask : t_rise

    task automatic t_fall;
        wr(ad(3, sge_pkg::REG_PTR), 32'h0);
        wr(ad(3, sge_pkg::REG_NTR), 32'h4);
        pin(3, 2, 1'b1);
        rc("evt no rise", ad(3, sge_pkg::REG_EVT), 32'h0);
        pin(3, 2, 1'b0);
        rc("evt fall", ad(3, sge_pkg::REG_EVT), 32'h4);
        wr(ad(3, sge_pkg::REG_PTR), 32'h4);
        pin(3, 2, 1'b1);
        rc("evt both r", ad(3, sge_pkg::REG_EVT), 32'h4);
        pin(3, 2, 1'b0);
        rc("evt both f", ad(3, sge_pkg::REG_EVT), 32'h4);
        wr(ad(3, sge_pkg::REG_PTR), 32'h7FFF);
        wr(ad(3, sge_pkg::REG_NTR), 32'h0);
    endtask : t_fall

    task automatic t_summary;
        wr(ad(4, sge_pkg::REG_EN), 32'h2);
        wr(ad(sge_pkg::MISC_GRP, sge_pkg::REG_IMSK), 32'h10);
        rc("imsk", ad(sge_pkg::MISC_GRP, sge_pkg::REG_IMSK), 32'h10);
        pin(4, 0, 1'b1);
        chk("sum masked", 32'h0, {27'h0, summary});
        chk("irq off", 32'h0, {31'h0, irq});
        pin(4, 1, 1'b1);
        chk("sum set", 32'h10, {27'h0, summary});
        chk("irq on", 32'h1, {31'h0, irq});
        rc("en kept", ad(4, sge_pkg::REG_EN), 32'h2);
        rc("stb cond", ad(0, sge_pkg::REG_COND), 32'h2);
        rc("ista", ad(sge_pkg::MISC_GRP, sge_pkg::REG_ISTA), 32'h10);
        repeat (2) @(posedge mclk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        wr(ad(4, sge_pkg::REG_EN), 32'h0);
        repeat (2) @(posedge mclk);
        chk("sum en off", 32'h0, {27'h0, summary});
        rc("evt dev", ad(4, sge_pkg::REG_EVT), 32'h3);
        rc("evt stb", ad(0, sge_pkg::REG_EVT), 32'h2);
        pin(4, 0, 1'b0);
        pin(4, 1, 1'b0);
        rc("evt stb fall", ad(0, sge_pkg::REG_EVT), 32'h0);
    endtask : t_summary

    task automatic t_cls_preset;
        pin(2, 3, 1'b1);
        wr(ad(sge_pkg::MISC_GRP, sge_pkg::REG_CTRL), 32'h1);
        rc("evt cls", ad(2, sge_pkg::REG_EVT), 32'h0);
        rc("ptr cls", ad(2, sge_pkg::REG_PTR), 32'h7FFF);
        pin(2, 3, 1'b0);
        wr(ad(3, sge_pkg::REG_PTR), 32'h0);
        wr(ad(3, sge_pkg::REG_NTR), 32'hFFFF);
        wr(ad(sge_pkg::MISC_GRP, sge_pkg::REG_CTRL), 32'h2);
        rc("ptr preset", ad(3, sge_pkg::REG_PTR), 32'h7FFF);
        rc("ntr preset", ad(3, sge_pkg::REG_NTR), 32'h0);
        wr(8'hC0, 32'h1);
        chk("err wr", 32'h1, {31'h0, err});
        rc("rd unmapped", 8'hE4, 32'h0);
        chk("err rd", 32'h1, {31'h0, err});
    endtask : t_cls_preset

    task automatic test_done;
        $display("n_fail=%0d comparisons=%0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done

    initial
    begin
        #100000;
        n_fail++;
        test_done();
    end

    initial
    begin
        n_fail = 0;
        comparisons = 0;
        reset_n <= 1'b0;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 8'h0;
        pwdata <= 32'h0;
        cond_pin <= '0;
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (4) @(posedge mclk);
        t_reset();
        t_filters();
        t_rise();
        t_fall();
        t_summary();
        t_cls_preset();
        test_done();
    end
endmodule : sge_top_tb
